// *** dv/msrb_host_model.sv ***
/*
 * controller model for the two-wire serial port: drives the link clock
 * and the data wire, samples read data. assumes tasks are called one
 * at a time; the link clock idles high between transactions.
 */
`timescale 1ns/1ps
`default_nettype none

module msrb_host_model (
	output logic sck,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe
);
	logic hbit = 1'b0;
	logic hen = 1'b0;

	// wire level; the host wins while it drives, as the device lets go only at the next rising edge,
	// and a line nobody drives shows the inverse of its last bit
	assign sdio_in = hen ? hbit : (sdio_oe ? sdio_out : ~hbit);

	initial sck = 1'b1;

	// bare link clock edges: during reset so the shifter settles, after it so
	// the reset synchroniser drains before the first counted edge
	task automatic idle_pulses(input int n);
		repeat (n) begin
			#7.5 sck = 1'b0;
			#7.5 sck = 1'b1;
		end
	endtask

	// one transaction, msb first; address bit 7 high means write
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			sck = 1'b0;
			hbit = (i > 7) ? a[i-8] : d[i];
			hen = a[7] || i > 7;
			#7.5 sck = 1'b1;
			#3;
			if (i < 8)
				q[i] = sdio_out;
			#4.5;
			// turnaround before the device drives
			if (i == 8 && !a[7])
				#300;
		end
		hen = 1'b0;
		// spacing between transactions, also covers write landing in the core
		#600;
	endtask
endmodule

`default_nettype wire

// *** dv/msrb_register_bank_props.sv ***
/*
 * port-level assertions for the motion sensor register bank.
 * assumes it is bound to msrb_register_bank and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module msrb_register_bank_props #(
	parameter int IDLE_FRAMES = 4
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic sdio_oe,
	input wire msrb_pkg::msrb_frame_t frame,
	input wire logic analog_off,
	input wire logic core_reset,
	input wire logic dump_rearm,
	input wire logic awake
);
	logic [15:0] still_cnt;
	logic [15:0] next_still_cnt;

	// motionless frames since the last moving frame; saturates so it never wraps to zero
	// a soft reset restarts the count, but a frame in its pulse cycle already counts
	always_comb begin
		next_still_cnt = still_cnt;
		if (frame.valid && (frame.dx != 8'sh00 || frame.dy != 8'sh00))
			next_still_cnt = 16'h0000;
		else if (core_reset)
			next_still_cnt = frame.valid ? 16'h0001 : 16'h0000;
		else if (frame.valid && still_cnt != 16'hffff)
			next_still_cnt = still_cnt + 16'h0001;
	end

	// counter register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			still_cnt <= 16'h0000;
		end else begin
			still_cnt <= next_still_cnt;
		end
	end

	a_release_state: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(sys_rst) |-> awake && !analog_off && !core_reset && !dump_rearm)
		else $error("outputs wrong after reset release");
	a_reset_pulse_once: assert property (@(posedge mclk) disable iff (sys_rst)
		core_reset |=> !core_reset)
		else $error("soft reset pulse longer than one cycle");
	a_rearm_pulse_once: assert property (@(posedge mclk) disable iff (sys_rst)
		dump_rearm |=> !dump_rearm)
		else $error("dump rearm pulse longer than one cycle");
	a_soft_reset_wakes: assert property (@(posedge mclk) disable iff (sys_rst)
		core_reset |-> ##[0:1] awake)
		else $error("soft reset left the part asleep");
	a_soft_reset_rearm: assert property (@(posedge mclk) disable iff (sys_rst)
		core_reset |-> ##[0:1] dump_rearm)
		else $error("soft reset did not rearm the dump");
	a_sleep_after_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(awake) |-> 32'(still_cnt) >= IDLE_FRAMES)
		else $error("fell asleep too early");
	a_sleep_on_frame: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(awake) |-> $past(frame.valid, 1) || $past(frame.valid, 2))
		else $error("fell asleep without a frame");
	a_read_drive_span: assert property (@(posedge sck) disable iff (sys_rst)
		$rose(sdio_oe) |-> sdio_oe [*8] ##1 !sdio_oe)
		else $error("read data drive span wrong");
endmodule

bind msrb_register_bank msrb_register_bank_props #(.IDLE_FRAMES(IDLE_FRAMES)) u_props (
	.mclk(mclk),
	.sys_rst(sys_rst),
	.sck(sck),
	.sdio_oe(sdio_oe),
	.frame(frame),
	.analog_off(analog_off),
	.core_reset(core_reset),
	.dump_rearm(dump_rearm),
	.awake(awake)
);

`default_nettype wire

// *** dv/tb_motion_sensor_register_bank.sv ***
/*
 * self-checking bench for the register bank: reset values, motion
 * accumulation, config writes, soft reset and sleep. assumes the host
 * model drives the serial port and frames are driven on mclk falls.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_motion_sensor_register_bank;
	localparam int IDLE = 4;
	localparam logic [2:0] PC = 3'h2; // arbitrary part code
	localparam int FW = $bits(msrb_pkg::msrb_frame_t);
	localparam logic [6:0] RA [13] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07,
		7'h09, 7'h0a, 7'h11, 7'h0b, 7'h10, 7'h7f};
	localparam logic [7:0] RV [13] = '{8'h00, {PC, 5'h01}, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00,
		8'h01, 8'h00, ~{PC, 5'h00}, 8'h00, 8'h00, 8'h00};
	logic mclk, sys_rst, sck, sdio_in, sdio_out, sdio_oe;
	logic analog_off, core_reset, dump_rearm, awake;
	msrb_pkg::msrb_frame_t frame;
	logic [7:0] dump_byte, q;
	logic signed [7:0] acc_x, acc_y;
	int err_total, checked, seed, cycles, rst_seen, rearm_seen;

	msrb_register_bank #(.IDLE_FRAMES(IDLE), .PART_CODE(PC)) u_dut (.mclk(mclk),
		.sys_rst(sys_rst), .sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe), .frame(frame), .dump_byte(dump_byte), .analog_off(analog_off),
		.core_reset(core_reset), .dump_rearm(dump_rearm), .awake(awake));
	msrb_host_model u_host (.sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe));

	// saturating accumulate, the expected motion register behaviour
	function automatic logic signed [7:0] sat(input logic signed [7:0] a,
		input logic signed [7:0] b);
		logic signed [8:0] s;
		s = a + b;
		if (s > 9'sd127)
			return msrb_pkg::MOTION_MAX;
		if (s < -9'sd128)
			return msrb_pkg::MOTION_MIN;
		return s[7:0];
	endfunction

	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic rd(input string n, input logic [6:0] a, input logic [7:0] e);
		u_host.xfer({1'b0, a}, 8'h00, q);
		check(n, q, e);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host.xfer({1'b1, a}, d, q);
	endtask

	// one frame with random statistics and the given motion
	task automatic send(input logic signed [7:0] x, input logic signed [7:0] y);
		@(negedge mclk);
		frame = FW'({$random(seed), $random(seed), $random(seed)});
		frame.valid = 1'b1;
		frame.dx = x;
		frame.dy = y;
		@(negedge mclk);
		frame.valid = 1'b0;
		acc_x = sat(acc_x, x);
		acc_y = sat(acc_y, y);
	endtask

	task automatic end_sim();
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// soft reset and rearm pulses seen outside reset, sampled where settled
	always @(negedge mclk) begin
		if (!sys_rst && core_reset)
			rst_seen++;
		if (!sys_rst && dump_rearm)
			rearm_seen++;
	end

	// hang guard, far above the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		seed = 32'h4035edac;
		sys_rst = 1'b1;
		frame = '0;
		acc_x = 8'sh00;
		acc_y = 8'sh00;
		dump_byte = 8'($random(seed));
		u_host.idle_pulses(4);
		repeat (15) @(negedge mclk);
		sys_rst = 1'b0;
		u_host.idle_pulses(2);
		repeat (4) @(negedge mclk);
		// reset values, unmapped reads and the live dump byte
		foreach (RA[i]) rd("reset_value", RA[i], RV[i]);
		rd("dump_byte", 7'h08, dump_byte);
		// random motion; wide steps reach both limits
		repeat (20) send(8'($random(seed)), 8'($random(seed)));
		rd("motion_y", 7'h02, acc_y);
		rd("motion_x", 7'h03, acc_x);
		rd("motion_y_clr", 7'h02, 8'h00);
		rd("motion_x_clr", 7'h03, 8'h00);
		repeat (3) send(8'sh7f, 8'sh80);
		rd("motion_y_min", 7'h02, 8'h80);
		rd("motion_x_max", 7'h03, 8'h7f);
		rd("surface_quality", 7'h04, frame.features[8:1]);
		rd("brightest", 7'h05, {2'b00, frame.brightest});
		rd("pixel_total", 7'h07, frame.pixel_sum[14:7]);
		rd("exposure_low", 7'h0a, frame.exposure[7:0]);
		// reserved bits dropped, unmapped and read-only writes ignored
		wr(7'h00, 8'h7e);
		wr(7'h0c, 8'hff);
		wr(7'h01, 8'hff);
		rd("config", 7'h00, 8'h40);
		rd("status", 7'h01, {PC, 5'h01});
		check("analog_off", {7'h00, analog_off}, 8'h01);
		// soft reset with other bits in the same write
		acc_x = 8'sh00;
		acc_y = 8'sh00;
		send(8'sh05, -8'sh03);
		wr(7'h00, 8'hc1);
		rd("config_rst", 7'h00, 8'h41);
		rd("motion_rst", 7'h03, 8'h00);
		check("analog_off", {7'h00, analog_off}, 8'h01);
		wr(7'h00, 8'h00);
		check("analog_on", {7'h00, analog_off}, 8'h00);
		// sleep after the idle count, forced awake holds
		repeat (IDLE - 2) send(8'sh00, 8'sh00);
		check("awake", {7'h00, awake}, 8'h01);
		repeat (3) send(8'sh00, 8'sh00);
		check("asleep", {7'h00, awake}, 8'h00);
		rd("status_sleep", 7'h01, {PC, 5'h00});
		wr(7'h00, 8'h01);
		repeat (IDLE + 2) send(8'sh00, 8'sh00);
		check("forced_awake", {7'h00, awake}, 8'h01);
		// mid-run reset clears the forced-awake config
		@(negedge mclk);
		sys_rst = 1'b1;
		u_host.idle_pulses(4);
		repeat (16) @(negedge mclk);
		sys_rst = 1'b0;
		u_host.idle_pulses(2);
		repeat (4) @(negedge mclk);
		rd("config_sysrst", 7'h00, 8'h00);
		check("awake_sysrst", {7'h00, awake}, 8'h01);
		check("analog_sysrst", {7'h00, analog_off}, 8'h00);
		// one soft reset; rearm from the dump read and the soft reset
		check("core_reset_pulses", 8'(rst_seen), 8'h01);
		check("dump_rearm_pulses", 8'(rearm_seen), 8'h02);
		end_sim();
	end
endmodule

`default_nettype wire

// *** hw/msrb_pkg.sv ***
/*
 * shared constants and types of the motion sensor register bank:
 * register offsets, field positions, reset values, frame counts and
 * the structs that carry frame statistics and serial write commands.
 * assumes nothing of its surroundings; compiled before every module.
 */
package msrb_pkg;

	// serial framing: one address byte (top bit = write) then one data byte
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int XFER_BITS = 16;
	localparam logic [3:0] LAST_ADDR_EDGE = 4'h7;
	localparam logic [3:0] FIRST_DATA_EDGE = 4'h8;
	localparam logic [3:0] LAST_DATA_EDGE = 4'hf;

	// register offsets
	localparam logic [6:0] ADDR_SENSOR_CONFIG = 7'h00;
	localparam logic [6:0] ADDR_SENSOR_STATUS = 7'h01;
	localparam logic [6:0] ADDR_MOTION_Y_COUNT = 7'h02;
	localparam logic [6:0] ADDR_MOTION_X_COUNT = 7'h03;
	localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h04;
	localparam logic [6:0] ADDR_BRIGHTEST_PIXEL = 7'h05;
	localparam logic [6:0] ADDR_DARKEST_PIXEL = 7'h06;
	localparam logic [6:0] ADDR_PIXEL_TOTAL_UPPER = 7'h07;
	localparam logic [6:0] ADDR_IMAGE_DUMP_PORT = 7'h08;
	localparam logic [6:0] ADDR_EXPOSURE_HIGH = 7'h09;
	localparam logic [6:0] ADDR_EXPOSURE_LOW = 7'h0a;
	localparam logic [6:0] ADDR_INVERTED_PART_CODE = 7'h11;

	// field positions
	localparam int SOFT_RESET_BIT = 7;
	localparam int ANALOG_OFF_BIT = 6;
	localparam int STAY_AWAKE_BIT = 0;
	localparam int PART_CODE_LSB = 5;
	localparam int AWAKE_BIT = 0;
	localparam logic [7:0] CONFIG_STORED_MASK = 8'hc1;

	// reset values
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	localparam logic [7:0] DARKEST_RESET = 8'h3f;
	localparam logic [7:0] EXPOSURE_HIGH_RESET = 8'h01;

	// motion limits
	localparam logic signed [7:0] MOTION_MAX = 8'sh7f;
	localparam logic signed [7:0] MOTION_MIN = 8'sh80;

	// sleep timing, counted in frames
	localparam int FRAMES_PER_SEC = 1500;
	localparam int SLEEP_SECONDS = 1;
	localparam int SLEEP_FRAMES = FRAMES_PER_SEC * SLEEP_SECONDS;

	// one serial write, handed from the link domain
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} msrb_wr_t;

	// per-frame results from the image processor
	typedef struct packed {
		logic valid;
		logic signed [7:0] dx;
		logic signed [7:0] dy;
		logic [8:0] features;
		logic [5:0] brightest;
		logic [5:0] darkest;
		logic [14:0] pixel_sum;
		logic [15:0] exposure;
	} msrb_frame_t;

endpackage

// *** hw/msrb_register_bank.sv ***
/*
 * register bank of the optical motion sensor: configuration, status,
 * motion accumulators that clear on read, surface quality and image
 * statistics, reached over the two-wire serial port.
 * assumes frame results arrive on mclk as one-cycle valid pulses and
 * the serial clock is a separate domain handled by msrb_serial_link.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: registers reachable serially at offsets 0x00-0x0a and 0x11.
// R2: config write with bit 7 resets the part; other bits still stored.
// R3: the reset bit clears itself after the reset is performed.
// R4: config bit 6 powers down the analog section.
// R5: without bit 0, sleep after one second of frames with no motion.
// R6: status holds part code in bits 7..5 and awake flag in bit 0.
// R7: motion registers are eight-bit two's complement, -128 to +127.
// R8: motion registers accumulate movement since the previous read.
// R9: reading a motion register returns its count then clears it.
// R10: surface quality is the upper eight bits of the nine-bit feature count.
// R11: writes to unmapped offsets are ignored; reads there return zero.
// R12: motion accumulators saturate at their signed limits.
// R13: reserved config and status bits read zero and ignore writes.
module msrb_register_bank #(
	parameter int IDLE_FRAMES = msrb_pkg::SLEEP_FRAMES,
	parameter int IDLE_W = 11,
	parameter logic [2:0] PART_CODE = 3'h5 // arbitrary value
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	input wire msrb_pkg::msrb_frame_t frame,
	input wire logic [7:0] dump_byte,
	output logic analog_off,
	output logic core_reset,
	output logic dump_rearm,
	output logic awake
);

	// the idle counter must be able to hold the full sleep delay
	if (IDLE_FRAMES < 1 || IDLE_FRAMES >= (1 << IDLE_W)) begin
		$error("IDLE_FRAMES does not fit in IDLE_W bits");
	end

	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_FRAMES - 1);

	typedef struct packed {
		logic [2:0] wr_sync;
		logic [2:0] rd_sync;
		logic [7:0] config_bits;
		logic signed [7:0] motion_x;
		logic signed [7:0] motion_y;
		logic [7:0] surface_q;
		logic [7:0] brightest;
		logic [7:0] darkest;
		logic [7:0] pixel_total;
		logic [7:0] expo_high;
		logic [7:0] expo_low;
		logic [7:0] rd_word;
		logic [IDLE_W-1:0] idle_frames;
		logic awake;
		logic analog_off;
		logic core_reset;
		logic dump_rearm;
	} msrb_bank_t;

	msrb_bank_t st;
	msrb_bank_t next_st;

	logic link_rd_tog;
	logic [6:0] link_rd_addr;
	logic link_wr_tog;
	msrb_pkg::msrb_wr_t link_wr_cmd;

	// serial shifter on the link clock
	msrb_serial_link u_link (
		.sck(sck),
		.sys_rst(sys_rst),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe),
		.rd_tog(link_rd_tog),
		.rd_addr(link_rd_addr),
		.wr_tog(link_wr_tog),
		.wr_cmd(link_wr_cmd),
		.rd_word(st.rd_word)
	);

	// saturating add: a fast swipe pins at the limit instead of wrapping
	function automatic logic signed [7:0] sat_add(
		input logic signed [7:0] base,
		input logic signed [7:0] delta
	);
		logic signed [8:0] sum;
		sum = 9'(base) + 9'(delta);
		if (sum > 9'(msrb_pkg::MOTION_MAX)) begin
			sat_add = msrb_pkg::MOTION_MAX; // R12
		end else if (sum < 9'(msrb_pkg::MOTION_MIN)) begin
			sat_add = msrb_pkg::MOTION_MIN; // R12
		end else begin
			sat_add = sum[7:0]; // R7
		end
	endfunction

	// read data for one offset; unmapped offsets read as zero
	function automatic logic [7:0] read_mux(
		input logic [6:0] addr,
		input msrb_bank_t s
	);
		unique case (addr)
			msrb_pkg::ADDR_SENSOR_CONFIG: begin
				read_mux = s.config_bits & msrb_pkg::CONFIG_STORED_MASK; // R13
			end
			msrb_pkg::ADDR_SENSOR_STATUS: begin
				read_mux = 8'(PART_CODE) << msrb_pkg::PART_CODE_LSB; // R6 R13
				read_mux[msrb_pkg::AWAKE_BIT] = s.awake; // R6
			end
			msrb_pkg::ADDR_MOTION_Y_COUNT: begin
				read_mux = s.motion_y;
			end
			msrb_pkg::ADDR_MOTION_X_COUNT: begin
				read_mux = s.motion_x;
			end
			msrb_pkg::ADDR_SURFACE_QUALITY: begin
				read_mux = s.surface_q;
			end
			msrb_pkg::ADDR_BRIGHTEST_PIXEL: begin
				read_mux = s.brightest;
			end
			msrb_pkg::ADDR_DARKEST_PIXEL: begin
				read_mux = s.darkest;
			end
			msrb_pkg::ADDR_PIXEL_TOTAL_UPPER: begin
				read_mux = s.pixel_total;
			end
			msrb_pkg::ADDR_IMAGE_DUMP_PORT: begin
				read_mux = dump_byte;
			end
			msrb_pkg::ADDR_EXPOSURE_HIGH: begin
				read_mux = s.expo_high;
			end
			msrb_pkg::ADDR_EXPOSURE_LOW: begin
				read_mux = s.expo_low;
			end
			msrb_pkg::ADDR_INVERTED_PART_CODE: begin
				read_mux = ~(8'(PART_CODE) << msrb_pkg::PART_CODE_LSB);
			end
			default: begin
				read_mux = 8'h00; // R11
			end
		endcase
	endfunction

	logic wr_evt;
	logic rd_evt;
	logic clr_x;
	logic clr_y;
	logic moved;

	// toggle edges from the link domain, seen after two synchroniser stages
	assign wr_evt = st.wr_sync[1] ^ st.wr_sync[2];
	assign rd_evt = st.rd_sync[1] ^ st.rd_sync[2];
	assign clr_x = rd_evt && link_rd_addr == msrb_pkg::ADDR_MOTION_X_COUNT;
	assign clr_y = rd_evt && link_rd_addr == msrb_pkg::ADDR_MOTION_Y_COUNT;
	assign moved = frame.valid && (frame.dx != 8'sh00 || frame.dy != 8'sh00);

	// whole next state of the bank
	always_comb begin
		next_st = st;
		next_st.wr_sync = {st.wr_sync[1:0], link_wr_tog};
		next_st.rd_sync = {st.rd_sync[1:0], link_rd_tog};
		next_st.core_reset = 1'b0;
		next_st.dump_rearm = 1'b0;

		// serial read: latch the word, then clear a motion register
		if (rd_evt) begin
			next_st.rd_word = read_mux(link_rd_addr, st); // R1 R11
			if (link_rd_addr == msrb_pkg::ADDR_IMAGE_DUMP_PORT) begin
				next_st.dump_rearm = 1'b1;
			end
		end
		if (clr_x) begin
			next_st.motion_x = 8'sh00; // R9
		end
		if (clr_y) begin
			next_st.motion_y = 8'sh00; // R9
		end

		// a frame adds onto zero when it lands in the clearing cycle, so
		// movement that races a read is kept, never lost
		if (frame.valid) begin
			next_st.motion_x = sat_add(clr_x ? 8'sh00 : st.motion_x, frame.dx); // R8
			next_st.motion_y = sat_add(clr_y ? 8'sh00 : st.motion_y, frame.dy); // R8
			next_st.surface_q = frame.features[8:1]; // R10
			next_st.brightest = {2'b00, frame.brightest};
			next_st.darkest = {2'b00, frame.darkest};
			next_st.pixel_total = frame.pixel_sum[14:7];
			next_st.expo_high = frame.exposure[15:8];
			next_st.expo_low = frame.exposure[7:0];
		end

		// sleep timer counts motionless frames
		if (st.config_bits[msrb_pkg::STAY_AWAKE_BIT] || moved) begin
			next_st.idle_frames = '0; // R5
			next_st.awake = 1'b1; // R5
		end else if (frame.valid && st.awake) begin
			if (st.idle_frames == IDLE_LAST) begin
				next_st.awake = 1'b0; // R5
			end else begin
				next_st.idle_frames = st.idle_frames + 1'b1;
			end
		end

		// soft reset: performed one cycle after the bit lands, then dropped
		if (st.config_bits[msrb_pkg::SOFT_RESET_BIT]) begin
			next_st.core_reset = 1'b1; // R2
			next_st.config_bits[msrb_pkg::SOFT_RESET_BIT] = 1'b0; // R3
			next_st.motion_x = 8'sh00;
			next_st.motion_y = 8'sh00;
			next_st.idle_frames = '0;
			next_st.awake = 1'b1;
			next_st.dump_rearm = 1'b1;
		end

		// serial write: only the control bits are kept, after the soft reset so it wins over it
		if (wr_evt) begin
			unique case (link_wr_cmd.addr)
				msrb_pkg::ADDR_SENSOR_CONFIG: begin
					next_st.config_bits = link_wr_cmd.data
						& msrb_pkg::CONFIG_STORED_MASK; // R2 R13
				end
				msrb_pkg::ADDR_IMAGE_DUMP_PORT: begin
					next_st.dump_rearm = 1'b1;
				end
				default: begin
					next_st.config_bits = st.config_bits
						& ~(8'h01 << msrb_pkg::SOFT_RESET_BIT); // R11
				end
			endcase
		end
		next_st.analog_off = next_st.config_bits[msrb_pkg::ANALOG_OFF_BIT]; // R4

		if (sys_rst) begin
			next_st.config_bits = msrb_pkg::CONFIG_RESET;
			next_st.motion_x = msrb_pkg::ZERO_RESET;
			next_st.motion_y = msrb_pkg::ZERO_RESET;
			next_st.surface_q = msrb_pkg::ZERO_RESET;
			next_st.brightest = msrb_pkg::ZERO_RESET;
			next_st.darkest = msrb_pkg::DARKEST_RESET;
			next_st.pixel_total = msrb_pkg::ZERO_RESET;
			next_st.expo_high = msrb_pkg::EXPOSURE_HIGH_RESET;
			next_st.expo_low = msrb_pkg::ZERO_RESET;
			next_st.rd_word = msrb_pkg::ZERO_RESET;
			next_st.idle_frames = '0;
			next_st.awake = 1'b1;
			next_st.analog_off = 1'b0;
			next_st.core_reset = 1'b0;
			next_st.dump_rearm = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	// outputs straight from the state flops
	assign analog_off = st.analog_off;
	assign core_reset = st.core_reset;
	assign dump_rearm = st.dump_rearm;
	assign awake = st.awake;

endmodule

`default_nettype wire

// *** hw/msrb_serial_link.sv ***
/*
 * link-side shifter of the register bank, clocked by the serial clock.
 * assumes the controller waits long enough between the address byte and
 * the data byte, and between transactions, that words handed across
 * to the core clock are stable when the other side samples them.
 */
`timescale 1ns/1ps
`default_nettype none

module msrb_serial_link (
	input wire logic sck,
	input wire logic sys_rst,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic rd_tog,
	output logic [6:0] rd_addr,
	output logic wr_tog,
	output msrb_pkg::msrb_wr_t wr_cmd,
	input wire logic [7:0] rd_word
);

	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic [3:0] edge_cnt;
		logic [7:0] shift;
		logic is_write;
		logic [6:0] addr;
		logic rd_tog;
		logic wr_tog;
		msrb_pkg::msrb_wr_t wr_cmd;
		logic [7:0] out_shift;
		logic sdio_out;
		logic sdio_oe;
	} msrb_link_t;

	msrb_link_t st;
	msrb_link_t next_st;

	// one step per rising serial clock edge
	always_comb begin
		next_st = st;
		next_st.rst_meta = sys_rst;
		next_st.rst_sync = st.rst_meta;
		next_st.shift = {st.shift[6:0], sdio_in};
		next_st.edge_cnt = st.edge_cnt + 4'h1;
		if (st.edge_cnt == 4'h0) begin
			// held last data bit is released at the next transaction's first edge
			next_st.sdio_oe = 1'b0;
		end
		if (st.edge_cnt == msrb_pkg::LAST_ADDR_EDGE) begin
			next_st.is_write = st.shift[6];
			next_st.addr = {st.shift[5:0], sdio_in};
			if (!st.shift[6]) begin
				next_st.rd_tog = ~st.rd_tog; // R1
			end
		end
		if (!st.is_write && st.edge_cnt >= msrb_pkg::FIRST_DATA_EDGE) begin
			// read word was settled in the core domain during the turnaround
			if (st.edge_cnt == msrb_pkg::FIRST_DATA_EDGE) begin
				next_st.sdio_out = rd_word[7];
				next_st.out_shift = {rd_word[6:0], 1'b0};
				next_st.sdio_oe = 1'b1;
			end else begin
				next_st.sdio_out = st.out_shift[7];
				next_st.out_shift = {st.out_shift[6:0], 1'b0};
			end
		end
		if (st.is_write && st.edge_cnt == msrb_pkg::LAST_DATA_EDGE) begin
			next_st.wr_cmd.addr = st.addr;
			next_st.wr_cmd.data = {st.shift[6:0], sdio_in};
			next_st.wr_tog = ~st.wr_tog; // R1
		end
		if (st.rst_sync) begin
			// toggles start from a known level; the core is still in reset while they settle
			next_st.rd_tog = 1'b0;
			next_st.wr_tog = 1'b0;
			next_st.edge_cnt = 4'h0;
			next_st.is_write = 1'b0;
			next_st.sdio_oe = 1'b0;
			next_st.sdio_out = 1'b0;
		end
	end

	always_ff @(posedge sck) begin
		st <= next_st;
	end

	assign sdio_out = st.sdio_out;
	assign sdio_oe = st.sdio_oe;
	assign rd_tog = st.rd_tog;
	assign rd_addr = st.addr;
	assign wr_tog = st.wr_tog;
	assign wr_cmd = st.wr_cmd;

endmodule

`default_nettype wire
